// ===== hw/chg_irq_top.v
/*
 Charger settings, interrupt enable and interrupt flag registers behind an
 I2C slave, with interrupt output and watchdog alarm source.
 Assumes event inputs come from same-clock logic; SCL and SDA are pins.
*/
`timescale 1ns/1ns
`include "chg_irq_regs.vh"

module chg_irq_top #(
   parameter [6:0] DEV_ADDR   = 7'h2a,  // Arbitrary bus address
   parameter [2:0] SYSV_RESET = 3'h0,   // Model-dependent voltage code
   parameter       SEC_CYCLES = `CHG_WD_TICK_S * `CHG_CLK_HZ
) (
   input  wire       ref_clk,              // 20 MHz clock
   input  wire       arst_n,               // Async reset, active low
   input  wire       scl_in,               // I2C clock pin
   input  wire       sda_in,               // I2C data pin level
   output reg        sda_out,              // I2C data drive value
   output reg        sda_oe,               // I2C data drive enable
   input  wire       ev_thermal_limit,     // Thermal limit event
   input  wire       ev_overtemp,          // Overtemperature event
   input  wire       ev_thermistor,        // Thermistor zone change
   input  wire       ev_battery,           // Battery threshold crossing
   input  wire       ev_mode_change,       // Charger mode change
   input  wire       ev_input_voltage,     // Input threshold crossing
   input  wire       wdog_enable,          // Watchdog enabled
   input  wire       wdog_kick,            // Watchdog restart pulse
   input  wire       wdog_period_sel,      // Watchdog period select
   input  wire       batt_above_vlim,      // Battery above voltage limit
   input  wire       sys_below_batt,       // System node below battery
   input  wire       batt_above_weak,      // Battery above weak level
   output reg        temp_compliance_en,   // Temperature compliance on
   output reg        temp_profile_sel,     // 0 first, 1 second profile
   output reg        charge_volt_limit_en, // Voltage limit active
   output reg  [1:0] ideal_diode_mode,     // Ideal diode policy
   output reg  [2:0] system_voltage_code,  // System voltage code
   output reg        charge_inhibit,       // Withhold charging
   output reg        ideal_diode_on,       // Ideal diode conducting
   output reg        wdog_expired,         // Watchdog expiry pulse
   output reg        irq_n                 // Interrupt, active low
);

   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_ADDR = 3'h1;
   localparam [2:0] S_ACK  = 3'h2;
   localparam [2:0] S_PTR  = 3'h3;
   localparam [2:0] S_WR   = 3'h4;
   localparam [2:0] S_RD   = 3'h5;
   localparam [2:0] S_RACK = 3'h6;

   reg  [2:0] scl_s_r;
   reg  [2:0] sda_s_r;
   reg        scl_f_r;
   reg        sda_f_r;
   reg        scl_p_r;
   reg        sda_p_r;
   reg  [2:0] state_r;
   reg  [2:0] after_r;
   reg  [2:0] cnt_r;
   reg  [7:0] sh_r;
   reg  [7:0] ptr_r;
   reg        ack_on_r;
   reg  [6:0] irq_en_r;
   reg  [6:0] flags_r;
   reg  [6:0] clr_r;
   wire       scl_rise;
   wire       scl_fall;
   wire       start_c;
   wire       stop_c;
   wire [7:0] byte_in;
   wire       wd_alarm;
   wire       wd_exp;
   wire [6:0] events;

   // ==========================================================
   // Register read decode; unmapped offsets read zero
   function [7:0] reg_read;
      input [7:0] addr;
      begin
         case (addr)
            `CHG_ADDR_FUNC_SET2: reg_read = {temp_compliance_en, temp_profile_sel,
                                             charge_volt_limit_en, ideal_diode_mode,
                                             system_voltage_code};
            `CHG_ADDR_IRQ_EN:    reg_read = {1'b0, irq_en_r};
            `CHG_ADDR_IRQ_ACT:   reg_read = {1'b0, flags_r};
            default:             reg_read = 8'h00;
         endcase
      end
   endfunction

   // ==========================================================
   // Pin synchronisers; level moves once stages 2 and 3 agree
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_s_r <= 3'h7;
         sda_s_r <= 3'h7;
         scl_f_r <= 1'b1;
         sda_f_r <= 1'b1;
         scl_p_r <= 1'b1;
         sda_p_r <= 1'b1;
      end else begin
         scl_s_r <= {scl_s_r[1:0], scl_in};
         sda_s_r <= {sda_s_r[1:0], sda_in};
         if (scl_s_r[1] == scl_s_r[2])
            scl_f_r <= scl_s_r[2];
         if (sda_s_r[1] == sda_s_r[2])
            sda_f_r <= sda_s_r[2];
         scl_p_r <= scl_f_r;
         sda_p_r <= sda_f_r;
      end
   end

   assign scl_rise = scl_f_r & ~scl_p_r;
   assign scl_fall = ~scl_f_r & scl_p_r;
   assign start_c  = scl_f_r & scl_p_r & sda_p_r & ~sda_f_r;
   assign stop_c   = scl_f_r & scl_p_r & ~sda_p_r & sda_f_r;
   assign byte_in  = {sh_r[6:0], sda_f_r};

   // ==========================================================
   // I2C slave: pointer byte then data, auto-incrementing
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r              <= S_IDLE;
         after_r              <= S_IDLE;
         cnt_r                <= 3'h0;
         sh_r                 <= 8'h00;
         ptr_r                <= 8'h00;
         ack_on_r             <= 1'b0;
         sda_out              <= 1'b0;
         sda_oe               <= 1'b0;
         clr_r                <= 7'h00;
         temp_compliance_en   <= 1'b0;
         temp_profile_sel     <= 1'b0;
         charge_volt_limit_en <= 1'b0;
         ideal_diode_mode     <= 2'h0;
         system_voltage_code  <= SYSV_RESET;
         irq_en_r             <= `CHG_RST_IRQ_EN;
      end else begin
         clr_r <= 7'h00;
         if (start_c) begin
            state_r <= S_ADDR;
            cnt_r   <= 3'h0;
            sda_oe  <= 1'b0;
         end else if (stop_c) begin
            state_r <= S_IDLE;
            sda_oe  <= 1'b0;
         end else if (scl_rise) begin
            case (state_r)
               S_ADDR, S_PTR, S_WR: begin
                  sh_r  <= byte_in;
                  cnt_r <= cnt_r + 3'h1;
                  if (cnt_r == 3'h7) begin
                     state_r  <= S_ACK;
                     ack_on_r <= 1'b0;
                     if (state_r == S_ADDR) begin
                        if (byte_in[7:1] != DEV_ADDR)
                           state_r <= S_IDLE;
                        after_r <= byte_in[0] ? S_RD : S_PTR;
                     end else if (state_r == S_PTR) begin
                        ptr_r   <= byte_in;
                        after_r <= S_WR;
                     end else begin
                        after_r <= S_WR;
                        ptr_r   <= ptr_r + 8'h01;
                        case (ptr_r)
                           `CHG_ADDR_FUNC_SET2: begin
                              temp_compliance_en   <= byte_in[`CHG_BIT_TEMP_EN];
                              temp_profile_sel     <= byte_in[`CHG_BIT_TEMP_SEL];
                              charge_volt_limit_en <= byte_in[`CHG_BIT_VLIM_EN];
                              ideal_diode_mode     <=
                                 byte_in[`CHG_DIODE_HI:`CHG_DIODE_LO];
                              system_voltage_code  <=
                                 byte_in[`CHG_SYSV_HI:`CHG_SYSV_LO];
                           end
                           `CHG_ADDR_IRQ_EN:
                              irq_en_r <= byte_in[6:0];
                           default: ;  // Flag register and holes ignore writes
                        endcase
                     end
                  end
               end
               S_RD: begin
                  cnt_r <= cnt_r + 3'h1;
                  if (cnt_r == 3'h7)
                     state_r <= S_RACK;
               end
               S_RACK: begin
                  // Master NACK ends the read; ACK fetches the next register
                  if (!sda_f_r) begin
                     state_r <= S_RD;
                     cnt_r   <= 3'h0;
                     sh_r    <= reg_read(ptr_r);
                     if (ptr_r == `CHG_ADDR_IRQ_ACT)
                        clr_r <= flags_r;
                     ptr_r   <= ptr_r + 8'h01;
                  end else begin
                     state_r <= S_IDLE;
                  end
               end
               default: ;
            endcase
         end else if (scl_fall) begin
            case (state_r)
               S_ACK: begin
                  if (!ack_on_r) begin
                     ack_on_r <= 1'b1;
                     sda_oe   <= 1'b1;
                  end else begin
                     state_r <= after_r;
                     cnt_r   <= 3'h0;
                     sda_oe  <= 1'b0;
                     if (after_r == S_RD) begin
                        sh_r   <= reg_read(ptr_r) << 1;
                        sda_oe <= ~|(reg_read(ptr_r) & 8'h80);
                        if (ptr_r == `CHG_ADDR_IRQ_ACT)
                           clr_r <= flags_r;
                        ptr_r  <= ptr_r + 8'h01;
                     end
                  end
               end
               S_RD: begin
                  sda_oe <= ~sh_r[7];
                  sh_r   <= {sh_r[6:0], 1'b0};
               end
               S_RACK:
                  sda_oe <= 1'b0;
               default: ;
            endcase
         end
      end
   end

   // ==========================================================
   // Watchdog alarm source
   chg_wdog_alarm #(
      .SEC_CYCLES (SEC_CYCLES)
   ) u_wdog (
      .ref_clk    (ref_clk),
      .arst_n     (arst_n),
      .enable     (wdog_enable),
      .kick       (wdog_kick),
      .period_sel (wdog_period_sel),
      .alarm      (wd_alarm),
      .expired    (wd_exp)
   );

   assign events = {ev_thermal_limit,
                    wd_alarm,
                    ev_overtemp,
                    ev_thermistor,
                    ev_battery,
                    ev_mode_change,
                    ev_input_voltage};

   // ==========================================================
   // Sticky flags; read clears what was read, a new event wins
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         flags_r        <= `CHG_RST_IRQ_ACT;
         irq_n          <= 1'b1;
         charge_inhibit <= 1'b0;
         ideal_diode_on <= 1'b0;
         wdog_expired   <= 1'b0;
      end else begin
         flags_r      <= (flags_r & ~clr_r) | events;
         irq_n        <= ~|(flags_r & irq_en_r);
         wdog_expired <= wd_exp;
         charge_inhibit <= charge_volt_limit_en & batt_above_vlim;
         case (ideal_diode_mode)
            `CHG_DIODE_ALWAYS: ideal_diode_on <= sys_below_batt;
            `CHG_DIODE_WEAK:   ideal_diode_on <= sys_below_batt & batt_above_weak;
            default:           ideal_diode_on <= 1'b0;
         endcase
      end
   end

endmodule // chg_irq_top

// ===== hw/chg_irq_regs.vh
/*
 Register map, field positions, reset values and timing counts of the charger
 settings and interrupt registers.
 Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef CHG_IRQ_REGS_VH
`define CHG_IRQ_REGS_VH

// ==========================================================
// Register offsets
`define CHG_ADDR_FUNC_SET2   8'h08
`define CHG_ADDR_IRQ_EN      8'h09
`define CHG_ADDR_IRQ_ACT     8'h0a

// ==========================================================
// Field positions
`define CHG_BIT_TEMP_EN      7
`define CHG_BIT_TEMP_SEL     6
`define CHG_BIT_VLIM_EN      5
`define CHG_DIODE_HI         4
`define CHG_DIODE_LO         3
`define CHG_SYSV_HI          2
`define CHG_SYSV_LO          0
`define CHG_FLAG_MASK        8'h7f
`define CHG_DIODE_ALWAYS     2'h0
`define CHG_DIODE_WEAK       2'h1

// ==========================================================
// Reset values
`define CHG_RST_FUNC_HI      5'h00
`define CHG_RST_IRQ_EN       7'h00
`define CHG_RST_IRQ_ACT      7'h00

// ==========================================================
// Timing
`define CHG_CLK_HZ           20000000
`define CHG_WD_TICK_S        1
`define CHG_WD_PERIOD0_S     7'h20
`define CHG_WD_PERIOD1_S     7'h40
`define CHG_WD_LEAD0_S       7'h02
`define CHG_WD_LEAD1_S       7'h04

`endif

// ===== hw/chg_wdog_alarm.v
/*
 Watchdog timer with early alarm for the charger interrupt logic.
 Assumes enable, kick and period select come from same-clock logic.
*/
`timescale 1ns/1ns
`include "chg_irq_regs.vh"

module chg_wdog_alarm #(
   parameter SEC_CYCLES = `CHG_WD_TICK_S * `CHG_CLK_HZ
) (
   input  wire       ref_clk,     // 20 MHz clock
   input  wire       arst_n,      // Async reset
   input  wire       enable,      // Watchdog running
   input  wire       kick,        // Restart pulse
   input  wire       period_sel,  // 0 short, 1 long period
   output reg        alarm,       // One-cycle early alarm
   output reg        expired      // One-cycle expiry pulse
);

   localparam [6:0] PER0 = `CHG_WD_PERIOD0_S;
   localparam [6:0] PER1 = `CHG_WD_PERIOD1_S;
   localparam [6:0] ALM0 = `CHG_WD_PERIOD0_S - `CHG_WD_LEAD0_S;
   localparam [6:0] ALM1 = `CHG_WD_PERIOD1_S - `CHG_WD_LEAD1_S;
   localparam [31:0] LAST = SEC_CYCLES - 1;

   reg  [31:0] pre_r;
   reg  [6:0]  sec_r;
   wire        tick;
   wire [6:0]  per;
   wire [6:0]  alm;

   assign tick = (pre_r == LAST);
   assign per  = period_sel ? PER1 : PER0;
   assign alm  = period_sel ? ALM1 : ALM0;

   // ==========================================================
   // Seconds count; stops at expiry until kicked or disabled
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_r   <= 32'h0;
         sec_r   <= 7'h00;
         alarm   <= 1'b0;
         expired <= 1'b0;
      end else begin
         alarm   <= 1'b0;
         expired <= 1'b0;
         if (!enable || kick) begin
            pre_r <= 32'h0;
            sec_r <= 7'h00;
         end else if (sec_r != per) begin
            pre_r <= tick ? 32'h0 : pre_r + 32'h1;
            if (tick) begin
               sec_r   <= sec_r + 7'h01;
               alarm   <= (sec_r + 7'h01 == alm);
               expired <= (sec_r + 7'h01 == per);
            end
         end
      end
   end

endmodule // chg_wdog_alarm

// ===== testbench/chg_irq_props.sv
/*
 Port-level assertions for the charger settings and interrupt block.
 Assumes a bind onto chg_irq_top: one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ns
module chg_irq_props #(
   parameter [2:0] SYSV_RESET = 3'h0,
   parameter       SEC_CYCLES = 20
) (
   input wire       ref_clk,              // Clock
   input wire       arst_n,               // Reset
   input wire       scl_in,               // SCL pin
   input wire       sda_out,              // SDA value
   input wire       sda_oe,               // SDA enable
   input wire       ev_thermal_limit,     // Event
   input wire       ev_overtemp,          // Event
   input wire       ev_thermistor,        // Event
   input wire       ev_battery,           // Event
   input wire       ev_mode_change,       // Event
   input wire       ev_input_voltage,     // Event
   input wire       wdog_enable,          // Watchdog on
   input wire       wdog_kick,            // Restart
   input wire       batt_above_vlim,      // Comparator
   input wire       sys_below_batt,       // Comparator
   input wire       batt_above_weak,      // Comparator
   input wire       temp_compliance_en,   // Setting
   input wire       temp_profile_sel,     // Setting
   input wire       charge_volt_limit_en, // Setting
   input wire [1:0] ideal_diode_mode,     // Setting
   input wire [2:0] system_voltage_code,  // Setting
   input wire       charge_inhibit,       // Inhibit
   input wire       ideal_diode_on,       // Diode
   input wire       wdog_expired,         // Expiry
   input wire       irq_n                 // Interrupt
);
   // ==========================================================
   // Helpers
   wire [7:0] cfg = {temp_compliance_en, temp_profile_sel, charge_volt_limit_en,
                     ideal_diode_mode, system_voltage_code};
   wire       any_ev = ev_thermal_limit | ev_overtemp | ev_thermistor | ev_battery |
                       ev_mode_change | ev_input_voltage;
   wire       diode_want = (ideal_diode_mode == 2'h0) ? sys_below_batt :
                           (ideal_diode_mode == 2'h1) & sys_below_batt & batt_above_weak;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // ==========================================================
   // Assertions
   a_reset_values: assert property ($rose(arst_n) |-> irq_n && !sda_oe && !wdog_expired &&
      cfg == {5'h00, SYSV_RESET}) else $error("outputs wrong after reset");
   a_cfg_scl_high: assert property ($changed(cfg) |-> scl_in)
      else $error("settings changed outside a bus write");
   a_inhibit_follow: assert property ($past(arst_n) |->
      charge_inhibit == $past(charge_volt_limit_en & batt_above_vlim))
      else $error("charge inhibit wrong");
   a_diode_policy: assert property ($past(arst_n) |-> ideal_diode_on == $past(diode_want))
      else $error("ideal diode state wrong");
   a_irq_has_cause: assert property ($fell(irq_n) |-> $past(any_ev) || $past(any_ev, 2) ||
      $past(any_ev, 3) || wdog_enable || scl_in) else $error("interrupt without cause");
   a_expiry_pulse: assert property (wdog_expired |-> $past(wdog_enable, 2) ##1 !wdog_expired)
      else $error("expiry pulse malformed");
   a_kick_restarts: assert property (wdog_kick |=> !wdog_expired [*8])
      else $error("expiry right after kick");
   a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("SDA driven while SCL high");
   a_open_drain: assert property (!sda_out)
      else $error("SDA drive value not low");
endmodule // chg_irq_props

// ===== testbench/chg_host_model.sv
/*
 Host-side I2C master model: drives SCL, pulls SDA low, reports read bytes.
 Assumes a pull-up on SDA, so a released line reads 1.
*/
`timescale 1ns/1ns
module chg_host_model #(
   parameter [6:0] DEV_ADDR = 7'h2a  // Slave address
) (
   input  wire       ref_clk,   // Clock
   input  wire       sda_in,    // Wire level
   output reg        scl,       // SCL drive
   output reg        sda_oe,    // Pull SDA low
   output reg  [7:0] rd_byte,   // Read data
   output reg        rd_valid   // Read strobe
);
   reg [8:0] r;
   reg [8:0] o;
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
      rd_byte = 8'h00;
      rd_valid = 1'b0;
   end
   task wait_cyc(input integer n);
      repeat (n) @(posedge ref_clk);
   endtask
   // SDA moves mid-low of SCL, clear of the slave's filter lag
   task start;
      wait_cyc(5);
      sda_oe <= 1'b0;
      wait_cyc(5);
      scl <= 1'b1;
      wait_cyc(10);
      sda_oe <= 1'b1;
      wait_cyc(10);
      scl <= 1'b0;
   endtask
   task stop;
      wait_cyc(5);
      sda_oe <= 1'b1;
      wait_cyc(5);
      scl <= 1'b1;
      wait_cyc(10);
      sda_oe <= 1'b0;
      wait_cyc(10);
   endtask
   task xfer(input [7:0] d, input mack);
      integer i;
      o = {d, mack};
      for (i = 8; i >= 0; i--) begin
         wait_cyc(5);
         sda_oe <= ~o[i];
         wait_cyc(5);
         scl <= 1'b1;
         wait_cyc(10);
         r[i] = sda_in;
         scl <= 1'b0;
      end
   endtask
   task write_reg(input [7:0] a, input [7:0] d);
      start;
      xfer({DEV_ADDR, 1'b0}, 1'b1);
      xfer(a, 1'b1);
      xfer(d, 1'b1);
      stop;
   endtask
   task read_reg(input [7:0] a);
      start;
      xfer({DEV_ADDR, 1'b0}, 1'b1);
      xfer(a, 1'b1);
      start;
      xfer({DEV_ADDR, 1'b1}, 1'b1);
      // Release SDA for the slave's byte, then NACK it
      xfer(8'hff, 1'b1);
      rd_byte <= r[8:1];
      rd_valid <= 1'b1;
      wait_cyc(1);
      rd_valid <= 1'b0;
      stop;
   endtask
endmodule // chg_host_model

// ===== testbench/charger_irq_and_path_config_test.sv
/*
 Self-checking bench for the charger settings and interrupt registers.
 Assumes the host model and checker are compiled first.
*/
`timescale 1ns/1ns
`include "chg_irq_regs.vh"
module charger_irq_and_path_config_test;
   localparam       SEC    = 20;
   localparam [2:0] SYSV_R = 3'h5;
   reg        ref_clk = 1'b0;
   reg        arst_n = 1'b0;
   reg  [6:0] ev = 7'h00;
   reg        wd_en = 1'b0;
   reg        wd_kick = 1'b0;
   reg        wd_sel = 1'b0;
   reg  [2:0] cmp = 3'h0;
   reg  [7:0] v;
   wire       scl, host_oe, sda_oe, rd_valid, irq_n, wdog_expired;
   wire [7:0] rd_byte, cfg;
   wire       sda = ~(sda_oe | host_oe);
   logic [7:0] exp_q[$];
   integer    num_errors = 0, n_checks = 0, cyc = 0, i, t1, t2;
   chg_irq_top #(.SYSV_RESET(SYSV_R), .SEC_CYCLES(SEC)) dut (
      .ref_clk(ref_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(),
      .sda_oe(sda_oe), .ev_thermal_limit(ev[6]), .ev_overtemp(ev[4]),
      .ev_thermistor(ev[3]), .ev_battery(ev[2]), .ev_mode_change(ev[1]),
      .ev_input_voltage(ev[0]), .wdog_enable(wd_en), .wdog_kick(wd_kick),
      .wdog_period_sel(wd_sel), .batt_above_vlim(cmp[2]), .sys_below_batt(cmp[1]),
      .batt_above_weak(cmp[0]), .temp_compliance_en(cfg[7]), .temp_profile_sel(cfg[6]),
      .charge_volt_limit_en(cfg[5]), .ideal_diode_mode(cfg[4:3]),
      .system_voltage_code(cfg[2:0]), .charge_inhibit(), .ideal_diode_on(),
      .wdog_expired(wdog_expired), .irq_n(irq_n));
   chg_host_model #(.DEV_ADDR(7'h2a)) host (.ref_clk(ref_clk), .sda_in(sda), .scl(scl),
      .sda_oe(host_oe), .rd_byte(rd_byte), .rd_valid(rd_valid));
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cmp <= 3'($urandom_range(7, 0));
   // ==========================================================
   // Checking
   task summarize;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task check(input [7:0] seen, input [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task rd_chk(input [7:0] a, input [7:0] e);
      exp_q.push_back(e);
      host.read_reg(a);
   endtask
   task pulse_ev(input [6:0] m);
      @(posedge ref_clk) ev <= m;
      @(posedge ref_clk) ev <= 7'h00;
      repeat (3) @(posedge ref_clk);
   endtask
   always @(posedge ref_clk) if (rd_valid === 1'b1) check(rd_byte, exp_q.pop_front());
   // Ceiling well above the roughly 28000 cycles the sequence needs
   always @(posedge ref_clk) begin
      cyc = cyc + 1;
      if (cyc == 90000) begin
         num_errors++;
         $display("mismatch at %0t: run did not finish", $time);
         summarize;
      end
   end
   // ==========================================================
   // Sequence
   initial begin
      void'($urandom(32'hbb9b0394));
      repeat (6) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      check(cfg, {5'h00, SYSV_R});
      rd_chk(`CHG_ADDR_FUNC_SET2, {5'h00, SYSV_R});
      rd_chk(`CHG_ADDR_IRQ_EN, 8'h00);
      rd_chk(`CHG_ADDR_IRQ_ACT, 8'h00);
      for (i = 0; i < 4; i++) begin
         v = $urandom;
         v[4:3] = i[1:0];
         host.write_reg(`CHG_ADDR_FUNC_SET2, v);
         rd_chk(`CHG_ADDR_FUNC_SET2, v);
         check(cfg, v);
      end
      host.write_reg(`CHG_ADDR_IRQ_EN, 8'hff);
      rd_chk(`CHG_ADDR_IRQ_EN, 8'h7f);
      host.write_reg(`CHG_ADDR_IRQ_ACT, 8'hff);
      rd_chk(`CHG_ADDR_IRQ_ACT, 8'h00);
      host.write_reg(`CHG_ADDR_IRQ_EN, 8'h5f);
      for (i = 0; i < 7; i++) if (i != 5) begin
         pulse_ev(7'h01 << i);
         check({7'h00, irq_n}, 8'h00);
         rd_chk(`CHG_ADDR_IRQ_ACT, 8'h01 << i);
         rd_chk(`CHG_ADDR_IRQ_ACT, 8'h00);
         check({7'h00, irq_n}, 8'h01);
      end
      host.write_reg(`CHG_ADDR_IRQ_EN, 8'h20);
      v = $urandom;
      pulse_ev(v[6:0] & 7'h5f);
      check({7'h00, irq_n}, 8'h01);
      host.write_reg(`CHG_ADDR_IRQ_EN, 8'h5f);
      check({7'h00, irq_n}, {7'h00, (v[6:0] & 7'h5f) == 7'h00});
      rd_chk(`CHG_ADDR_IRQ_ACT, {1'b0, v[6:0] & 7'h5f});
      for (i = 0; i < 2; i++) begin
         host.write_reg(`CHG_ADDR_IRQ_EN, 8'h20);
         @(posedge ref_clk) wd_sel <= i[0];
         wd_kick <= 1'b1;
         wd_en <= 1'b1;
         @(posedge ref_clk) wd_kick <= 1'b0;
         t1 = 0;
         while (irq_n !== 1'b0 && t1 < 3000) begin
            @(posedge ref_clk);
            t1++;
         end
         t2 = 0;
         while (wdog_expired !== 1'b1 && t2 < 300) begin
            @(posedge ref_clk);
            t2++;
         end
         check({7'h00, t2 >= (2 + 2 * i) * SEC - 4 && t2 <= (2 + 2 * i) * SEC + 4}, 8'h01);
         t1 = t1 + t2 - (32 + 32 * i) * SEC;
         check({7'h00, t1 >= -6 && t1 <= 6}, 8'h01);
         wd_en <= 1'b0;
         rd_chk(`CHG_ADDR_IRQ_ACT, 8'h20);
      end
      summarize;
   end
endmodule // charger_irq_and_path_config_test
bind chg_irq_top chg_irq_props #(.SYSV_RESET(SYSV_RESET), .SEC_CYCLES(SEC_CYCLES)) u_props (
   .ref_clk, .arst_n, .scl_in, .sda_out, .sda_oe, .ev_thermal_limit, .ev_overtemp,
   .ev_thermistor, .ev_battery, .ev_mode_change, .ev_input_voltage, .wdog_enable,
   .wdog_kick, .batt_above_vlim, .sys_below_batt, .batt_above_weak, .temp_compliance_en,
   .temp_profile_sel, .charge_volt_limit_en, .ideal_diode_mode, .system_voltage_code,
   .charge_inhibit, .ideal_diode_on, .wdog_expired, .irq_n);
